/* node_state_regs.vh */
// Purpose: Constants for the node state indicator
// Assumes: 20 MHz clk_sys
// Notes:   Times in ns, counts derived from the clock period
`ifndef NODE_STATE_REGS_VH
`define NODE_STATE_REGS_VH
`define CLK_PERIOD_NS      50
// Flicker half period, 10 Hz full cycle
`define FLICKER_HALF_NS    50000000
`define FLICKER_HALF_CYC   (`FLICKER_HALF_NS / `CLK_PERIOD_NS)
// Flash pattern period, 1 Hz
`define PATTERN_NS         1000000000
`define PATTERN_CYC        (`PATTERN_NS / `CLK_PERIOD_NS)
// One flash slot: 200 ms on or off phase
`define SLOT_NS            200000000
`define SLOT_CYC           (`SLOT_NS / `CLK_PERIOD_NS)
// Five slots make one pattern period; pulses sit in the even slots
`define SLOT_W             3
`define SLOT_FIRST         3'h0
`define SLOT_SECOND        3'h2
`define SLOT_THIRD         3'h4
`define SLOT_LAST          3'h4
`define SLOT_ONE           3'h1
`define CNT_ONE            32'h00000001
// Default frame-watch timeout
`define TIMEOUT_NS         1000000000
`define TIMEOUT_CYC        (`TIMEOUT_NS / `CLK_PERIOD_NS)
`define CNT_W              32
`define ST_W               5
`define ST_NOT_ACTIVE      5'h01
`define ST_BASIC_ETH       5'h02
`define ST_PREOP1          5'h04
`define ST_PREOP2          5'h08
`define ST_READY           5'h10
`endif

/* node_state_indicator.v */
// Purpose: Node state machine and dual status light driver
// Assumes: Inputs synchronous to clk_sys; frame detectors are pulses
// Notes:   Later states beyond ready-to-operate are not modelled
//
// How it works
// R1: Green and red status lights; meaning depends on selected mode.
// R2: Plain Ethernet mode drives green steadily on.
// R3: Green stays off in the not-active state.
// R4: Managing node: no frame before timeout moves to pre-operational one.
// R5: Managing node: traffic seen before timeout keeps managing operation off.
// R6: Controlled node: no frame before timeout moves to basic Ethernet.
// R7: Controlled node: traffic before timeout moves to pre-operational one.
// R8: Basic Ethernet flickers green at about ten hertz.
// R9: Managing node leaves basic Ethernet only by interface reset.
// R10: Controlled node in basic Ethernet goes pre-operational one on traffic.
// R11: Pre-operational one shows a single green flash each second.
// R12: Managing node in pre-operational one runs reduced cycle, no cyclic traffic.
// R13: Controlled node in pre-operational one accepts configuration.
// R14: Controlled node in pre-operational one moves on start-of-cycle frame.
// R15: Controlled node in pre-operational one lights red if manager failed.
// R16: Pre-operational two shows a double green flash each second.
// R17: Indicator mirrors the termination switch.
// R18: Controlled node in pre-operational two configures, then ready on command.
// R19: Flashes are short pulses at period start, off for the rest; in ready the third pulse runs to one cycle before the period end.
`timescale 1ns/1ps
`default_nettype none
`include "node_state_regs.vh"
module node_state_indicator (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        ethernet_mode,
  input  wire        managing_node,
  input  wire [31:0] timeout_cyc,
  input  wire        proto_frame,
  input  wire        soc_frame,
  input  wire        ready_cmd,
  input  wire        config_write,
  input  wire        manager_lost,
  input  wire        term_switch,
  output reg         led_green,
  output reg         led_red,
  output reg         termination_indicator,
  output reg         managing_active,
  output reg         reduced_cycle,
  output reg         config_accept,
  output reg  [4:0]  node_state
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [`ST_W-1:0]   state_q;
  reg  [`ST_W-1:0]   state_d;
  reg  [`CNT_W-1:0]  tmo_q;
  reg  [`CNT_W-1:0]  tmo_d;
  reg                mn_block_q;
  reg                mn_block_d;
  reg  [`CNT_W-1:0]  flick_q;
  reg  [`CNT_W-1:0]  flick_d;
  reg                flick_lvl_q;
  reg                flick_lvl_d;
  reg  [`CNT_W-1:0]  slot_cnt_q;
  reg  [`CNT_W-1:0]  slot_cnt_d;
  reg  [`SLOT_W-1:0] slot_idx_q;
  reg  [`SLOT_W-1:0] slot_idx_d;
  reg                green_d;
  reg                red_d;
  reg                term_d;
  reg                mn_run_d;
  reg                config_d;
  // Combinational helpers
  wire               tmo_done;
  wire               proto_mode;
  wire               is_ctrl_node;
  wire               in_preop;
  wire               in_managed;
  wire               state_moves;
  wire               slot_end;
  wire               pattern_end;

  // ------------------------------------------------------------
  // Shared conditions
  // ------------------------------------------------------------
  assign tmo_done     = (tmo_q >= timeout_cyc);
  assign proto_mode   = !ethernet_mode;
  assign is_ctrl_node = !managing_node;
  assign in_preop     = (state_q == `ST_PREOP1) || (state_q == `ST_PREOP2);
  assign in_managed   = in_preop || (state_q == `ST_READY);
  assign state_moves  = (state_d != state_q);
  assign slot_end     = (slot_cnt_q == `SLOT_CYC - 1);
  assign pattern_end  = slot_end && (slot_idx_q == `SLOT_LAST);

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  // Ethernet mode freezes the node where it stands; protocol
  // events are ignored until the mode switch goes back.
  always @*
  begin
    state_d = state_q;
    if (proto_mode)
    begin
      case (state_q)
        `ST_NOT_ACTIVE:
        begin
          if (managing_node)
          begin
            // Foreign traffic blocks start; timeout alone cannot rescue it
            if (tmo_done && !mn_block_q && !proto_frame)
              state_d = `ST_PREOP1; // R4 R5
          end
          else if (proto_frame)
            state_d = `ST_PREOP1; // R7
          else if (tmo_done)
            state_d = `ST_BASIC_ETH; // R6
        end
        `ST_BASIC_ETH:
        begin
          // A managing node never lands here, and could only leave by reset
          if (is_ctrl_node && proto_frame)
            state_d = `ST_PREOP1; // R9 R10
        end
        `ST_PREOP1:
        begin
          if (is_ctrl_node && soc_frame)
            state_d = `ST_PREOP2; // R14
        end
        `ST_PREOP2:
        begin
          if (is_ctrl_node && ready_cmd)
            state_d = `ST_READY; // R18
        end
        `ST_READY:
        begin
          state_d = state_q;
        end
        default:
        begin
          // Illegal codes fall back to the dark not-active state
          state_d = `ST_NOT_ACTIVE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Timeout window
  // ------------------------------------------------------------
  // The window only runs while protocol mode waits in the
  // not-active state, so Ethernet mode cannot expire it unseen.
  always @*
  begin
    tmo_d      = tmo_q;
    mn_block_d = mn_block_q;
    if (proto_mode && state_q == `ST_NOT_ACTIVE && !tmo_done)
    begin
      // Saturates at the limit so the window cannot wrap and fire twice
      tmo_d = tmo_q + `CNT_ONE;
      // Sticky until reset: a foreign manager rules this node out
      if (managing_node && proto_frame)
        mn_block_d = 1'b1; // R5
    end
  end

  // ------------------------------------------------------------
  // Pattern timers
  // ------------------------------------------------------------
  // Flicker runs free; its phase carries no meaning.
  always @*
  begin
    flick_d     = flick_q + `CNT_ONE;
    flick_lvl_d = flick_lvl_q;
    if (flick_q == `FLICKER_HALF_CYC - 1)
    begin
      flick_d     = {`CNT_W{1'b0}};
      flick_lvl_d = ~flick_lvl_q; // R8
    end
  end

  // Slot counter instead of a divide: a wide divider for a
  // light pattern would cost far more than two small counters.
  always @*
  begin
    slot_cnt_d = slot_cnt_q + `CNT_ONE;
    slot_idx_d = slot_idx_q;
    if (state_moves || pattern_end)
    begin
      // Restart on a state change so a first flash is never cut short
      slot_cnt_d = {`CNT_W{1'b0}};
      slot_idx_d = `SLOT_FIRST;
    end
    else if (slot_end)
    begin
      slot_cnt_d = {`CNT_W{1'b0}};
      slot_idx_d = slot_idx_q + `SLOT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Light and status decode
  // ------------------------------------------------------------
  always @*
  begin
    green_d = 1'b0;
    if (ethernet_mode)
    begin
      green_d = 1'b1; // R1 R2
    end
    else
    begin
      case (state_q)
        `ST_NOT_ACTIVE:
        begin
          green_d = 1'b0; // R3
        end
        `ST_BASIC_ETH:
        begin
          green_d = flick_lvl_q; // R8
        end
        `ST_PREOP1:
        begin
          green_d = (slot_idx_q == `SLOT_FIRST); // R11 R19
        end
        `ST_PREOP2:
        begin
          green_d = (slot_idx_q == `SLOT_FIRST) || (slot_idx_q == `SLOT_SECOND); // R16 R19
        end
        `ST_READY:
        begin
          // Third pulse fills its slot, so trim one cycle to keep pulses apart
          green_d = (slot_idx_q == `SLOT_FIRST) || (slot_idx_q == `SLOT_SECOND)
                    || ((slot_idx_q == `SLOT_THIRD) && !slot_end); // R19
        end
        default:
        begin
          green_d = 1'b0;
        end
      endcase
    end
  end

  always @*
  begin
    red_d    = 1'b0;
    config_d = 1'b0;
    mn_run_d = 1'b0;
    term_d   = term_switch; // R17
    if (proto_mode && is_ctrl_node)
    begin
      // A managing node never lights red; it has no manager to lose
      red_d    = manager_lost && in_managed; // R15
      config_d = config_write && in_preop; // R13 R18
    end
    if (proto_mode && managing_node && state_q == `ST_PREOP1)
    begin
      mn_run_d = 1'b1; // R12
    end
  end

  // ------------------------------------------------------------
  // Registers, outputs straight from flip-flops
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_q     <= `ST_NOT_ACTIVE;
      tmo_q       <= {`CNT_W{1'b0}};
      mn_block_q  <= 1'b0;
      flick_q     <= {`CNT_W{1'b0}};
      flick_lvl_q <= 1'b0;
      slot_cnt_q  <= {`CNT_W{1'b0}};
      slot_idx_q  <= `SLOT_FIRST;
    end
    else
    begin
      state_q     <= state_d;
      tmo_q       <= tmo_d;
      mn_block_q  <= mn_block_d;
      flick_q     <= flick_d;
      flick_lvl_q <= flick_lvl_d;
      slot_cnt_q  <= slot_cnt_d;
      slot_idx_q  <= slot_idx_d;
    end
  end

  // Status outputs lag the internal state by one edge
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      led_green             <= 1'b0;
      led_red               <= 1'b0;
      termination_indicator <= 1'b0;
      managing_active       <= 1'b0;
      reduced_cycle         <= 1'b0;
      config_accept         <= 1'b0;
      node_state            <= `ST_NOT_ACTIVE;
    end
    else
    begin
      led_green             <= green_d;
      led_red               <= red_d;
      termination_indicator <= term_d;
      managing_active       <= mn_run_d;
      reduced_cycle         <= mn_run_d;
      config_accept         <= config_d;
      node_state            <= state_q;
    end
  end

endmodule // node_state_indicator
`default_nettype wire

/* node_state_chk.sv */
// Purpose: Port checks for node_state_indicator
// Assumes: One clock, synchronous active-low reset
// Notes:   State and lights lag the internal state by one edge
`timescale 1ns/1ps
`default_nettype none
module node_state_chk (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       ethernet_mode,
  input wire logic       managing_node,
  input wire logic       proto_frame,
  input wire logic       soc_frame,
  input wire logic       manager_lost,
  input wire logic       term_switch,
  input wire logic       led_green,
  input wire logic       led_red,
  input wire logic       termination_indicator,
  input wire logic       managing_active,
  input wire logic       reduced_cycle,
  input wire logic [4:0] node_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence cn_run;
    !managing_node && !ethernet_mode;
  endsequence
  a_term_mirror: assert property (1 |=> termination_indicator == $past(term_switch))
    else $error("termination indicator lag wrong");
  a_eth_green: assert property (ethernet_mode |=> led_green)
    else $error("green not steady in Ethernet mode");
  a_idle_dark: assert property (node_state == 5'h01 && !$past(ethernet_mode) |-> !led_green)
    else $error("green lit while not active");
  a_basic_cn: assert property ($rose(node_state[1]) |-> !managing_node)
    else $error("managing node in basic Ethernet");
  a_cn_traffic: assert property (cn_run ##0 (node_state == 5'h01 && proto_frame && !soc_frame) |-> ##2 node_state == 5'h04)
    else $error("traffic did not start pre-operational one");
  a_soc_step: assert property (cn_run ##0 (node_state == 5'h04 && soc_frame && !$past(soc_frame)) |-> ##2 node_state == 5'h08)
    else $error("start of cycle did not advance");
  a_mn_start: assert property ($rose(managing_active) |-> managing_node && node_state == 5'h04 && reduced_cycle)
    else $error("managing start in wrong state");
  a_red_light: assert property (led_red == (!$past(managing_node) && !$past(ethernet_mode) && $past(manager_lost)
    && |node_state[4:2]))
    else $error("red light wrong");
endmodule // node_state_chk
`default_nettype wire

/* peer_nodes.sv */
// Purpose: Other nodes on the bus, seen as event pulses
// Assumes: Changes at the falling edge like all stimulus
// Notes:   Each event is one clock wide so nothing is seen twice
`timescale 1ns/1ps
`default_nettype none
module peer_nodes (
  input  wire logic clk_sys,
  output var  logic proto_frame,
  output var  logic soc_frame,
  output var  logic ready_cmd,
  output var  logic config_write
);
  initial {proto_frame, soc_frame, ready_cmd, config_write} = 4'h0;
  // k: 3 frame, 2 start of cycle, 1 ready command, 0 configuration
  task automatic send(input int k);
    @(negedge clk_sys);
    {proto_frame, soc_frame, ready_cmd, config_write} = 4'h1 << k;
    @(negedge clk_sys);
    {proto_frame, soc_frame, ready_cmd, config_write} = 4'h0;
  endtask
endmodule // peer_nodes
`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench for node_state_indicator
// Assumes: Timeouts of 100 cycles, 50 in mn_idle, keep the run short
// Notes:   Flash and flicker periods are too long to time here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0, nrst = 1'b0, ethernet_mode = 1'b0, managing_node = 1'b0;
  logic        manager_lost = 1'b0, term_switch = 1'b0;
  logic [31:0] timeout_cyc = 32'h00000064;
  logic        proto_frame, soc_frame, ready_cmd, config_write, led_green, led_red;
  logic        termination_indicator, managing_active, reduced_cycle, config_accept;
  logic [4:0]  node_state;
  int          bad_count = 0, checks_done = 0;
  always #25 clk_sys = ~clk_sys;
  peer_nodes peer (
    .clk_sys      (clk_sys),
    .proto_frame  (proto_frame),
    .soc_frame    (soc_frame),
    .ready_cmd    (ready_cmd),
    .config_write (config_write)
  );
  node_state_indicator uut (
    .clk_sys               (clk_sys),
    .nrst                  (nrst),
    .ethernet_mode         (ethernet_mode),
    .managing_node         (managing_node),
    .timeout_cyc           (timeout_cyc),
    .proto_frame           (proto_frame),
    .soc_frame             (soc_frame),
    .ready_cmd             (ready_cmd),
    .config_write          (config_write),
    .manager_lost          (manager_lost),
    .term_switch           (term_switch),
    .led_green             (led_green),
    .led_red               (led_red),
    .termination_indicator (termination_indicator),
    .managing_active       (managing_active),
    .reduced_cycle         (reduced_cycle),
    .config_accept         (config_accept),
    .node_state            (node_state)
  );
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic restart(input logic mn, input logic [31:0] tmo);
    nrst = 1'b0;
    managing_node = mn;
    timeout_cyc = tmo;
    wait_n(8);
    nrst = 1'b1;
  endtask
  task automatic cn_path;
    restart(1'b0, 32'h00000064);
    chk({4'h0, led_green}, 5'h00);
    peer.send(3);
    wait_n(1);
    chk(node_state, 5'h04);
    wait_n(2);
    chk({4'h0, led_green}, 5'h01);
    peer.send(0);
    chk({4'h0, config_accept}, 5'h01);
    manager_lost = 1'b1;
    wait_n(2);
    chk({4'h0, led_red}, 5'h01);
    manager_lost = 1'b0;
    peer.send(2);
    wait_n(1);
    chk(node_state, 5'h08);
    chk({4'h0, led_green}, 5'h01);
    peer.send(1);
    wait_n(1);
    chk(node_state, 5'h10);
    chk({4'h0, led_green}, 5'h01);
  endtask
  task automatic cn_idle;
    restart(1'b0, 32'h00000064);
    wait_n(90);
    chk(node_state, 5'h01);
    wait_n(20);
    chk(node_state, 5'h02);
    peer.send(3);
    wait_n(1);
    chk(node_state, 5'h04);
  endtask
  // Shorter window here so the timeout input itself is exercised
  task automatic mn_idle;
    restart(1'b1, 32'h00000032);
    wait_n(40);
    chk(node_state, 5'h01);
    wait_n(20);
    chk(node_state, 5'h04);
    chk({4'h0, reduced_cycle}, 5'h01);
  endtask
  // Foreign traffic must hold off the managing role for good
  task automatic mn_busy;
    restart(1'b1, 32'h00000064);
    peer.send(3);
    wait_n(150);
    chk(node_state, 5'h01);
    chk({4'h0, managing_active}, 5'h00);
  endtask
  task automatic eth_mode;
    restart(1'b0, 32'h00000064);
    ethernet_mode = 1'b1;
    term_switch = 1'b1;
    wait_n(2);
    chk({4'h0, led_green}, 5'h01);
    chk({4'h0, termination_indicator}, 5'h01);
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    cn_path;
    cn_idle;
    mn_idle;
    mn_busy;
    eth_mode;
    wrap_up;
  end
  initial
  begin
    #100us;
    bad_count++;
    wrap_up;
  end
endmodule // testbench
bind node_state_indicator node_state_chk chk (
  .clk_sys               (clk_sys),
  .nrst                  (nrst),
  .ethernet_mode         (ethernet_mode),
  .managing_node         (managing_node),
  .proto_frame           (proto_frame),
  .soc_frame             (soc_frame),
  .manager_lost          (manager_lost),
  .term_switch           (term_switch),
  .led_green             (led_green),
  .led_red               (led_red),
  .termination_indicator (termination_indicator),
  .managing_active       (managing_active),
  .reduced_cycle         (reduced_cycle),
  .node_state            (node_state)
);
`default_nettype wire
